// ---- ubg_map.vh ----
// Constants for the baud generator with auto-baud and wake on break
`ifndef UBG_MAP_VH
`define UBG_MAP_VH

// Prescale masks for the base tick (oscillator / 64, 16, 4)
`define UBG_BASE_MASK_SLOW   9'h03f
`define UBG_BASE_MASK_MID    9'h00f
`define UBG_BASE_MASK_FAST   9'h003
// Prescale masks for the auto-baud tick (oscillator / 512, 128, 32)
`define UBG_ABD_MASK_SLOW    9'h1ff
`define UBG_ABD_MASK_MID     9'h07f
`define UBG_ABD_MASK_FAST    9'h01f
// Reset value of the divisor halves
`define UBG_DIVISOR_RESET    8'h00
// Auto-baud counter start value
`define UBG_ABD_START        16'h0001
// Counter value that overflows on the next increment
`define UBG_ABD_LAST         16'hffff
// Rising edges of the sync character, the last ends the eighth bit
`define UBG_SYNC_RISES       3'h5

`endif

// ---- ubg_sync.v ----
// Two flip-flop synchroniser for the receive line
`timescale 1ns/1ps
`default_nettype none

module ubg_sync (
   input  wire core_clk_i,
   input  wire resetn_i,
   input  wire async_i,
   output wire sync_o
);

   reg stage1;
   reg stage2;

   // Line idles high, so reset to one
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         stage1 <= 1'b1;
         stage2 <= 1'b1;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
      end
   end

   assign sync_o = stage2;

endmodule // ubg_sync

`default_nettype wire

// ---- ubg_prescale.v ----
// Oscillator prescaler giving the base tick and the auto-baud tick
`timescale 1ns/1ps
`default_nettype none

module ubg_prescale (
   input  wire       core_clk_i,
   input  wire       resetn_i,
   input  wire       run_i,
   input  wire       clear_i,
   input  wire [8:0] base_mask_i,
   input  wire [8:0] abd_mask_i,
   output reg        base_tick_o,
   output reg        abd_tick_o
);

   reg  [8:0] count;
   wire [8:0] next_count;

   assign next_count = count + 9'h001;

   // Free counter, ticks when the masked bits are all ones
   always @(posedge core_clk_i) begin
      if (!resetn_i || clear_i) begin
         count       <= 9'h000;
         base_tick_o <= 1'b0;
         abd_tick_o  <= 1'b0;
      end else if (run_i) begin
         count       <= next_count;
         base_tick_o <= ((count & base_mask_i) == base_mask_i);
         abd_tick_o  <= ((count & abd_mask_i) == abd_mask_i);
      end else begin
         base_tick_o <= 1'b0;
         abd_tick_o  <= 1'b0;
      end
   end

endmodule // ubg_prescale

`default_nettype wire

// ---- ubg_core.v ----
// Baud divider, auto-baud measurement and wake-on-break detector
`timescale 1ns/1ps
`default_nettype none
`include "ubg_map.vh"

module ubg_core (
   input  wire        core_clk_i,
   input  wire        resetn_i,
   input  wire        port_enable_i,
   input  wire        sync_mode_i,
   input  wire        sleep_i,
   input  wire        wide_divider_select_i,
   input  wire        high_speed_select_i,
   input  wire        divisor_low_wr_i,
   input  wire        divisor_high_wr_i,
   input  wire [7:0]  divisor_wdata_i,
   input  wire        autobaud_enable_set_i,
   input  wire        autobaud_enable_clr_i,
   input  wire        autobaud_overflow_clr_i,
   input  wire        wake_on_break_enable_set_i,
   input  wire        wake_on_break_enable_clr_i,
   input  wire        data_read_i,
   input  wire        char_received_i,
   input  wire        rx_busy_i,
   input  wire        receive_line_i,
   output reg         bit_tick_o,
   output wire [7:0]  divisor_low_byte_o,
   output wire [7:0]  divisor_high_byte_o,
   output reg         autobaud_enable_o,
   output reg         autobaud_overflow_flag_o,
   output reg         wake_on_break_enable_o,
   output reg         receive_pending_flag_o,
   output wire        receive_idle_status_o,
   output wire        receiver_hold_o,
   output reg         wake_event_o
);

   // Auto-baud states, one-hot
   localparam [3:0] AB_OFF   = 4'h1;
   localparam [3:0] AB_START = 4'h2;
   localparam [3:0] AB_RISE  = 4'h4;
   localparam [3:0] AB_MEAS  = 4'h8;

   // Wake detector states, one-hot
   localparam [2:0] WK_OFF   = 3'h1;
   localparam [2:0] WK_WATCH = 3'h2;
   localparam [2:0] WK_BREAK = 3'h4;

   reg  [7:0]  divisor_low_byte;
   reg  [7:0]  divisor_high_byte;
   reg  [15:0] div_count;
   reg  [3:0]  ab_state;
   reg  [3:0]  next_ab_state;
   reg  [2:0]  wk_state;
   reg  [2:0]  next_wk_state;
   reg  [2:0]  rise_count;
   reg         line_prev;
   reg  [8:0]  base_mask;
   reg  [8:0]  abd_mask;
   wire        line_now;
   wire        line_rise;
   wire        line_fall;
   wire        hs_eff;
   wire        run;
   wire        base_tick;
   wire        abd_tick;
   wire [15:0] divisor_pair;
   wire [15:0] div_limit;
   wire        divisor_wr;
   wire        ab_measuring;
   wire        ab_fifth;
   wire        ab_overflow;
   wire        wake_fall;
   wire        wake_rise;

   // Receive line from the pin, two flops before use
   ubg_sync u_sync (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .async_i    (receive_line_i),
      .sync_o     (line_now)
   );

   // Edge detect on the synchronised line
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         line_prev <= 1'b1;
      end else begin
         line_prev <= line_now;
      end
   end

   assign line_rise = line_now & ~line_prev;
   assign line_fall = ~line_now & line_prev;

   assign hs_eff = high_speed_select_i & ~sync_mode_i;

   always @* begin
      case ({wide_divider_select_i, hs_eff})
         2'b00: begin
            base_mask = `UBG_BASE_MASK_SLOW;
            abd_mask  = `UBG_ABD_MASK_SLOW;
         end
         2'b01, 2'b10: begin
            base_mask = `UBG_BASE_MASK_MID;
            abd_mask  = `UBG_ABD_MASK_MID;
         end
         2'b11: begin
            base_mask = `UBG_BASE_MASK_FAST;
            abd_mask  = `UBG_ABD_MASK_FAST;
         end
         default: begin
            base_mask = `UBG_BASE_MASK_SLOW;
            abd_mask  = `UBG_ABD_MASK_SLOW;
         end
      endcase
   end

   assign run = port_enable_i & ~sleep_i;

   // Shared prescaler for both tick rates
   ubg_prescale u_prescale (
      .core_clk_i  (core_clk_i),
      .resetn_i    (resetn_i),
      .run_i       (run),
      .clear_i     (~port_enable_i),
      .base_mask_i (base_mask),
      .abd_mask_i  (abd_mask),
      .base_tick_o (base_tick),
      .abd_tick_o  (abd_tick)
   );

   assign divisor_pair = {divisor_high_byte, divisor_low_byte};
   assign divisor_wr   = divisor_low_wr_i | divisor_high_wr_i;

   assign div_limit = wide_divider_select_i ? divisor_pair :
                      {8'h00, divisor_low_byte};

   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         div_count  <= 16'h0000;
         bit_tick_o <= 1'b0;
      end else if (!port_enable_i || divisor_wr || ab_measuring) begin
         div_count  <= 16'h0000;
         bit_tick_o <= 1'b0;
      end else if (run && base_tick) begin
         if (div_count >= div_limit) begin
            div_count  <= 16'h0000;
            bit_tick_o <= 1'b1;
         end else begin
            div_count  <= div_count + 16'h0001;
            bit_tick_o <= 1'b0;
         end
      end else begin
         bit_tick_o <= 1'b0;
      end
   end

   assign ab_measuring = (ab_state == AB_MEAS);
   assign ab_fifth     = ab_measuring & line_rise &
                         (rise_count == (`UBG_SYNC_RISES - 3'h1));
   assign ab_overflow  = ab_measuring & run & abd_tick &
                         (divisor_pair == `UBG_ABD_LAST);

   // Auto-baud next state
   always @* begin
      next_ab_state = ab_state;
      case (ab_state)
         AB_OFF: begin
            if (autobaud_enable_set_i) begin
               next_ab_state = AB_START;
            end
         end
         AB_START: begin
            if (!wake_on_break_enable_o && line_fall && run) begin
               next_ab_state = AB_RISE;
            end
         end
         AB_RISE: begin
            if (line_rise && run) begin
               next_ab_state = AB_MEAS;
            end
         end
         AB_MEAS: begin
            if (ab_fifth) begin
               next_ab_state = AB_OFF;
            end
         end
         default: next_ab_state = AB_OFF;
      endcase
      if (autobaud_enable_clr_i || !port_enable_i) begin
         next_ab_state = AB_OFF;
      end
   end

   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         ab_state <= AB_OFF;
      end else begin
         ab_state <= next_ab_state;
      end
   end

   // Rising edges seen during measurement
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         rise_count <= 3'h0;
      end else if (ab_state == AB_RISE) begin
         rise_count <= 3'h1;
      end else if (ab_measuring && line_rise) begin
         rise_count <= rise_count + 3'h1;
      end
   end

   // Divisor halves: software writes, or the auto-baud count
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         divisor_low_byte  <= `UBG_DIVISOR_RESET;
         divisor_high_byte <= `UBG_DIVISOR_RESET;
      end else if (ab_state == AB_RISE && line_rise && run) begin
         {divisor_high_byte, divisor_low_byte} <= `UBG_ABD_START;
      end else if (ab_measuring && !ab_fifth && run && abd_tick) begin
         {divisor_high_byte, divisor_low_byte} <=
            divisor_pair + 16'h0001;
      end else if (!ab_measuring) begin
         if (divisor_low_wr_i) begin
            divisor_low_byte <= divisor_wdata_i;
         end
         if (divisor_high_wr_i) begin
            divisor_high_byte <= divisor_wdata_i;
         end
      end
   end

   assign divisor_low_byte_o  = divisor_low_byte;
   assign divisor_high_byte_o = divisor_high_byte;

   // Auto-baud enable flag, set by software
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         autobaud_enable_o <= 1'b0;
      end else if (ab_fifth || autobaud_enable_clr_i || !port_enable_i) begin
         autobaud_enable_o <= 1'b0;
      end else if (autobaud_enable_set_i) begin
         autobaud_enable_o <= 1'b1;
      end
   end

   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         autobaud_overflow_flag_o <= 1'b0;
      end else if (ab_overflow) begin
         autobaud_overflow_flag_o <= 1'b1;
      end else if (autobaud_overflow_clr_i) begin
         autobaud_overflow_flag_o <= 1'b0;
      end
   end

   assign wake_fall = (wk_state == WK_WATCH) & line_fall;
   assign wake_rise = (wk_state == WK_BREAK) & line_rise;

   // Wake detector next state
   always @* begin
      next_wk_state = wk_state;
      case (wk_state)
         WK_OFF: begin
            if (wake_on_break_enable_set_i && !sync_mode_i &&
                port_enable_i) begin
               next_wk_state = WK_WATCH;
            end
         end
         WK_WATCH: begin
            if (line_fall) begin
               next_wk_state = WK_BREAK;
            end
         end
         WK_BREAK: begin
            if (line_rise) begin
               next_wk_state = WK_OFF;
            end
         end
         default: next_wk_state = WK_OFF;
      endcase
      if (wake_on_break_enable_clr_i || sync_mode_i || !port_enable_i) begin
         next_wk_state = WK_OFF;
      end
   end

   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         wk_state <= WK_OFF;
      end else begin
         wk_state <= next_wk_state;
      end
   end

   // Wake enable bit mirrors the detector and its event pulse
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         wake_on_break_enable_o <= 1'b0;
         wake_event_o           <= 1'b0;
      end else begin
         wake_on_break_enable_o <= (next_wk_state != WK_OFF);
         wake_event_o           <= wake_fall;
      end
   end

   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         receive_pending_flag_o <= 1'b0;
      end else if (wake_fall || ab_fifth || ab_overflow ||
                   char_received_i) begin
         receive_pending_flag_o <= 1'b1;
      end else if (data_read_i) begin
         receive_pending_flag_o <= 1'b0;
      end
   end

   assign receive_idle_status_o = ~autobaud_enable_o & ~rx_busy_i;

   assign receiver_hold_o = autobaud_enable_o | wake_on_break_enable_o |
                            sleep_i;

endmodule // ubg_core

`default_nettype wire

// ---- ubg_core_chk.sv ----
// Port checker for the baud generator core
`timescale 1ns/1ps
`default_nettype none
module ubg_core_chk (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic port_enable_i,
   input wire logic sync_mode_i,
   input wire logic sleep_i,
   input wire logic data_read_i,
   input wire logic autobaud_enable_clr_i,
   input wire logic bit_tick_o,
   input wire logic autobaud_enable_o,
   input wire logic autobaud_overflow_flag_o,
   input wire logic wake_on_break_enable_o,
   input wire logic receive_pending_flag_o,
   input wire logic receive_idle_status_o,
   input wire logic receiver_hold_o,
   input wire logic wake_event_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   // Calibration and wake watch keep the receiver parked
   a_abd_not_idle:
      assert property (autobaud_enable_o |-> !receive_idle_status_o)
      else $error("idle status high during auto-baud");
   a_hold_rx:
      assert property ((autobaud_enable_o || wake_on_break_enable_o)
         |-> receiver_hold_o) else $error("receiver not held");
   // Wake event behaviour
   a_wake_pend:
      assert property (wake_event_o |-> ##[0:1] receive_pending_flag_o)
      else $error("wake event without pending flag");
   a_wake_armed:
      assert property (wake_event_o |-> $past(wake_on_break_enable_o))
      else $error("wake event while disarmed");
   a_sync_no_wake:
      assert property (sync_mode_i && $past(sync_mode_i)
         && !$past(wake_on_break_enable_o) |-> !wake_on_break_enable_o)
      else $error("wake armed in synchronous mode");
   // Divider output shape and sleep freeze
   a_tick_single:
      assert property (bit_tick_o |=> !bit_tick_o)
      else $error("bit tick longer than one cycle");
   a_sleep_quiet:
      assert property (sleep_i [*4] |-> !bit_tick_o)
      else $error("bit tick during sleep");
   // Pending flag sources and clears
   a_abd_done_pend:
      assert property ($fell(autobaud_enable_o) && $past(resetn_i)
         && !$past(autobaud_enable_clr_i) && $past(port_enable_i)
         |-> receive_pending_flag_o)
      else $error("auto-baud end without pending flag");
   a_ovf_pend:
      assert property ($rose(autobaud_overflow_flag_o)
         |-> receive_pending_flag_o) else $error("overflow without pending");
   a_pend_clear:
      assert property ($fell(receive_pending_flag_o) |-> $past(data_read_i)
         || !$past(port_enable_i) || !$past(resetn_i))
      else $error("pending cleared without data read");

   c_abd_done: cover property ($fell(autobaud_enable_o));
   c_wake: cover property (wake_event_o);
   c_tick: cover property (bit_tick_o);
endmodule // ubg_core_chk

bind ubg_core ubg_core_chk u_chk (.core_clk_i, .resetn_i, .port_enable_i,
   .sync_mode_i, .sleep_i, .data_read_i, .autobaud_enable_clr_i, .bit_tick_o,
   .autobaud_enable_o, .autobaud_overflow_flag_o, .wake_on_break_enable_o,
   .receive_pending_flag_o, .receive_idle_status_o, .receiver_hold_o,
   .wake_event_o);
`default_nettype wire

// ---- ubg_node.sv ----
// Remote serial node model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module ubg_node (
   input  wire logic clk_i,
   output var  logic line_o
);
   // Line idles at mark level
   initial line_o = 1'b1;

   // Drive one level for a number of clocks
   task automatic hold(input logic v, input int n);
      @(posedge clk_i);
      line_o <= v;
      repeat (n - 1) @(posedge clk_i);
   endtask

   // LSB-first frame, start and stop bits
   task automatic send_byte(input logic [7:0] b, input int t);
      hold(1'b0, t);
      for (int i = 0; i < 8; i++) hold(b[i], t);
      hold(1'b1, t);
   endtask

   // thirteen zero bit times, line left low
   task automatic send_break(input int t);
      hold(1'b0, 13 * t);
   endtask
endmodule // ubg_node
`default_nettype wire

// ---- ubg_core_tb_top.sv ----
// Self-checking testbench for the baud generator core
`timescale 1ns/1ps
`default_nettype none
module ubg_core_tb_top;
   localparam LW = 0, HW = 1, AS = 2, AC = 3, OC = 4, WS = 5, WC = 6, RD = 7;
   localparam CR = 8;
   logic       core_clk_i = 1'b0;
   logic       resetn_i   = 1'b0;
   logic       port_en    = 1'b0;
   logic       sync_m     = 1'b0;
   logic       sleep      = 1'b0;
   logic       wide       = 1'b0;
   logic       hs         = 1'b0;
   logic       rx_busy    = 1'b0;
   logic [8:0] pls        = 9'h000;
   logic [7:0] wdata      = 8'h00;
   wire        line, tick, abd_en, ovf, wake_en, pend, idle, hold, wake_ev;
   wire  [7:0] div_lo, div_hi;
   int         error_cnt  = 0;
   int         n_checks   = 0;
   int         n_wake     = 0;
   int         n;
   int         exp_p[5]   = '{128, 32, 8224, 2056, 128};

   // 20 MHz clock
   always #25 core_clk_i = ~core_clk_i;

   ubg_core dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .port_enable_i(port_en), .sync_mode_i(sync_m), .sleep_i(sleep),
      .wide_divider_select_i(wide), .high_speed_select_i(hs),
      .divisor_low_wr_i(pls[0]), .divisor_high_wr_i(pls[1]),
      .divisor_wdata_i(wdata), .autobaud_enable_set_i(pls[2]),
      .autobaud_enable_clr_i(pls[3]), .autobaud_overflow_clr_i(pls[4]),
      .wake_on_break_enable_set_i(pls[5]), .wake_on_break_enable_clr_i(pls[6]),
      .data_read_i(pls[7]), .char_received_i(pls[8]), .rx_busy_i(rx_busy),
      .receive_line_i(line), .bit_tick_o(tick), .divisor_low_byte_o(div_lo),
      .divisor_high_byte_o(div_hi), .autobaud_enable_o(abd_en),
      .autobaud_overflow_flag_o(ovf), .wake_on_break_enable_o(wake_en),
      .receive_pending_flag_o(pend), .receive_idle_status_o(idle),
      .receiver_hold_o(hold), .wake_event_o(wake_ev));

   ubg_node node (.clk_i(core_clk_i), .line_o(line));

   // Count wake pulses where outputs are settled
   always @(negedge core_clk_i) if (wake_ev === 1'b1) n_wake++;

   task automatic chk_bit(input string s, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %b seen %b", s, e, g);
      end
   endtask

   task automatic chk_val(input string s, input int e, input logic [15:0] g,
                          input int tol);
      n_checks++;
      if ((^g === 1'bx) || (g + tol < e) || (g > e + tol)) begin
         error_cnt++;
         $display("MISMATCH %s expected %0d seen %0d", s, e, g);
      end
   endtask

   // One-cycle control pulse, launched on a rising edge
   task automatic pulse(input int i);
      @(posedge core_clk_i);
      pls[i] <= 1'b1;
      @(posedge core_clk_i);
      pls[i] <= 1'b0;
   endtask

   task automatic wr(input int i, input logic [7:0] d);
      @(posedge core_clk_i);
      wdata <= d;
      pulse(i);
   endtask

   task automatic wt(input int k);
      repeat (k) @(negedge core_clk_i);
   endtask

   task automatic cfg(input logic s, input logic w, input logic h);
      @(posedge core_clk_i);
      sync_m <= s;
      wide <= w;
      hs <= h;
   endtask

   // Cycles up to the next bit tick, capped at lim
   task automatic wait_tick(input int lim, output int c);
      c = 0;
      do begin
         @(negedge core_clk_i);
         c++;
      end while (tick !== 1'b1 && c < lim);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Watchdog, about twice the expected run
   initial begin
      #3000000;
      error_cnt++;
      tally_and_finish;
   end

   initial begin
      repeat (8) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      port_en <= 1'b1;
      wr(HW, 8'h02);
      // Period per mode: index bit 2 sync, bit 1 wide, bit 0 or bit 2 high speed
      for (int k = 0; k < 5; k++) begin
         cfg(k[2], k[1], k[0] | k[2]);
         wr(LW, 8'h01);
         wait_tick(9000, n);
         wait_tick(9000, n);
         chk_val("tick period", exp_p[k], n[15:0], 0);
      end
      @(posedge core_clk_i);
      sleep <= 1'b1;
      wt(2);
      wait_tick(300, n);
      chk_val("ticks in sleep", 300, n[15:0], 0);
      @(posedge core_clk_i);
      sleep <= 1'b0;
      // Divisor write mid-period restarts the count
      cfg(1'b0, 1'b0, 1'b1);
      wr(LW, 8'h03);
      wait_tick(200, n);
      wt(40);
      wr(LW, 8'h03);
      wait_tick(200, n);
      chk_val("tick after write", 57, n[15:0], 10);
      // Plain auto-baud on a sync character
      cfg(1'b0, 1'b1, 1'b1);
      pulse(AS);
      wt(1);
      chk_bit("abd enable", 1'b1, abd_en);
      chk_bit("rx hold", 1'b1, hold);
      chk_bit("idle in abd", 1'b0, idle);
      node.send_byte(8'h55, 400);
      wt(8);
      chk_bit("abd enable", 1'b0, abd_en);
      chk_bit("pending", 1'b1, pend);
      chk_bit("idle after abd", 1'b1, idle);
      chk_bit("overflow", 1'b0, ovf);
      chk_val("abd count", 101, {div_hi, div_lo}, 1);
      pulse(RD);
      wt(1);
      chk_bit("pending read", 1'b0, pend);
      // Overflow clearing sequence: read, idle seen, then clear
      chk_bit("idle before ovf clear", 1'b1, idle);
      pulse(OC);
      wt(1);
      chk_bit("overflow cleared", 1'b0, ovf);
      // Wake on break with auto-baud armed
      chk_bit("idle before wake", 1'b1, idle);
      pulse(WS);
      pulse(AS);
      node.send_break(40);
      wt(1);
      chk_val("wake events", 1, n_wake[15:0], 0);
      chk_bit("pending on wake", 1'b1, pend);
      chk_bit("wake enable in break", 1'b1, wake_en);
      chk_bit("hold in wake", 1'b1, hold);
      pulse(RD);
      wt(1);
      chk_bit("pending read", 1'b0, pend);
      node.hold(1'b1, 40);
      wt(1);
      chk_bit("wake enable end", 1'b0, wake_en);
      chk_bit("abd waiting", 1'b1, abd_en);
      node.send_byte(8'h55, 80);
      wt(8);
      chk_bit("abd enable", 1'b0, abd_en);
      chk_val("abd count", 21, {div_hi, div_lo}, 1);
      pulse(RD);
      // Software abort of auto-baud releases the receiver
      pulse(AS);
      pulse(AC);
      wt(1);
      chk_bit("abd abort", 1'b0, abd_en);
      chk_bit("idle after abort", 1'b1, idle);
      // Software disarm of wake
      pulse(WS);
      pulse(WC);
      wt(1);
      chk_bit("wake disarm", 1'b0, wake_en);
      // Wake detector still watches the line in sleep
      @(posedge core_clk_i);
      sleep <= 1'b1;
      pulse(WS);
      node.hold(1'b0, 40);
      wt(1);
      chk_bit("pending wake in sleep", 1'b1, pend);
      node.hold(1'b1, 40);
      wt(1);
      chk_bit("wake end in sleep", 1'b0, wake_en);
      @(posedge core_clk_i);
      sleep <= 1'b0;
      pulse(RD);
      wt(1);
      chk_bit("pending read sleep", 1'b0, pend);
      // Synchronous mode refuses wake, receiver sets pending
      cfg(1'b1, 1'b0, 1'b0);
      pulse(WS);
      wt(1);
      chk_bit("wake in sync", 1'b0, wake_en);
      pulse(CR);
      wt(1);
      chk_bit("pending char", 1'b1, pend);
      // Busy receiver reports not idle
      @(posedge core_clk_i);
      rx_busy <= 1'b1;
      wt(1);
      chk_bit("idle while busy", 1'b0, idle);
      tally_and_finish;
   end
endmodule // ubg_core_tb_top
`default_nettype wire
